/* logic/ledic_defines.svh */
// offsets, field positions, reset values and timing counts of the indicator block
`ifndef LEDIC_DEFINES_SVH
`define LEDIC_DEFINES_SVH

`define LEDIC_CFG_OFFSET      8'h14
`define LEDIC_FIRST_MSB       15
`define LEDIC_FIRST_LSB       12
`define LEDIC_SECOND_MSB      11
`define LEDIC_SECOND_LSB      8
`define LEDIC_THIRD_MSB       7
`define LEDIC_THIRD_LSB       4
`define LEDIC_FREQ_MSB        3
`define LEDIC_FREQ_LSB        2
`define LEDIC_STRETCH_BIT     1
`define LEDIC_CFG_RESET       16'h0422
`define LEDIC_CLK_HZ          100000000
`define LEDIC_TICK_MS         1
`define LEDIC_TICK_CYCLES     ((`LEDIC_CLK_HZ / 1000) * `LEDIC_TICK_MS)
`define LEDIC_STRETCH0_MS     30
`define LEDIC_STRETCH1_MS     60
`define LEDIC_STRETCH2_MS     100
`define LEDIC_FAST_HALF_MS    50
`define LEDIC_SLOW_HALF_MS    250

`endif

/* logic/ledic_pkg.sv */
// types of the indicator block
package ledic_pkg;
    typedef enum logic [3:0] {
        LEDIC_SEL_SPEED     = 4'h0,
        LEDIC_SEL_TX        = 4'h1,
        LEDIC_SEL_RX        = 4'h2,
        LEDIC_SEL_COL       = 4'h3,
        LEDIC_SEL_LINK      = 4'h4,
        LEDIC_SEL_DUPLEX    = 4'h5,
        LEDIC_SEL_UNUSED6   = 4'h6,
        LEDIC_SEL_ACT       = 4'h7,
        LEDIC_SEL_ON        = 4'h8,
        LEDIC_SEL_OFF       = 4'h9,
        LEDIC_SEL_FAST      = 4'hA,
        LEDIC_SEL_SLOW      = 4'hB,
        LEDIC_SEL_LINK_RX   = 4'hC,
        LEDIC_SEL_LINK_ACT  = 4'hD,
        LEDIC_SEL_DUP_COL   = 4'hE,
        LEDIC_SEL_UNUSED15  = 4'hF
    } ledic_sel_e;
    typedef logic [6:0] ledic_ms_t;
endpackage

/* logic/ledic_tick.sv */
// millisecond tick and blink enables divided from hclk
`timescale 1ns/100ps
`include "ledic_defines.svh"
module ledic_tick (
    input  wire logic hclk,
    input  wire logic hresetn,
    output logic      ms_tick,
    output logic      fast_blink,
    output logic      slow_blink
);
    localparam int TICK_N = `LEDIC_TICK_CYCLES;
    logic [16:0] div_cnt;
    logic [8:0]  fast_cnt;
    logic [8:0]  slow_cnt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt <= 17'h00000;
            ms_tick <= 1'b0;
        end else if (div_cnt == 17'(TICK_N - 1)) begin
            div_cnt <= 17'h00000;
            ms_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 17'h00001;
            ms_tick <= 1'b0;
        end
    end

    // fast and slow test blink square waves
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fast_cnt   <= 9'h000;
            slow_cnt   <= 9'h000;
            fast_blink <= 1'b0;
            slow_blink <= 1'b0;
        end else if (ms_tick) begin
            if (fast_cnt == 9'(`LEDIC_FAST_HALF_MS - 1)) begin
                fast_cnt   <= 9'h000;
                fast_blink <= ~fast_blink;
            end else begin
                fast_cnt <= fast_cnt + 9'h001;
            end
            if (slow_cnt == 9'(`LEDIC_SLOW_HALF_MS - 1)) begin
                slow_cnt   <= 9'h000;
                slow_blink <= ~slow_blink;
            end else begin
                slow_cnt <= slow_cnt + 9'h001;
            end
        end
    end
endmodule

/* logic/ledic_channel.sv */
// one indicator channel: source select, stretch and combined display
`timescale 1ns/100ps
`include "ledic_defines.svh"
module ledic_channel (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [3:0] sel,
    input  wire logic       stretch_en,
    input  wire logic [6:0] stretch_ms,
    input  wire logic       ms_tick,
    input  wire logic       fast_blink,
    input  wire logic       slow_blink,
    input  wire logic       speed_100,
    input  wire logic       tx_event,
    input  wire logic       rx_event,
    input  wire logic       col_event,
    input  wire logic       link_up,
    input  wire logic       full_duplex,
    output logic            led_on
);
    logic       event_in;
    logic       combined;
    logic       primary;
    logic [6:0] stretch_cnt;
    logic       stretched;
    logic       blink_phase;
    logic       next_led;

    always_comb begin
        event_in = 1'b0;
        primary  = 1'b0;
        combined = 1'b0;
        unique case (ledic_pkg::ledic_sel_e'(sel))
            ledic_pkg::LEDIC_SEL_TX:       event_in = tx_event;
            ledic_pkg::LEDIC_SEL_RX:       event_in = rx_event;
            ledic_pkg::LEDIC_SEL_COL:      event_in = col_event;
            ledic_pkg::LEDIC_SEL_ACT:      event_in = tx_event | rx_event;
            ledic_pkg::LEDIC_SEL_LINK_RX: begin
                event_in = rx_event;
                primary  = link_up;
                combined = 1'b1;
            end
            ledic_pkg::LEDIC_SEL_LINK_ACT: begin
                event_in = tx_event | rx_event;
                primary  = link_up;
                combined = 1'b1;
            end
            ledic_pkg::LEDIC_SEL_DUP_COL: begin
                event_in = col_event;
                primary  = full_duplex;
                combined = 1'b1;
            end
            default: event_in = 1'b0;
        endcase
    end

    // each new event restarts the timer; combined modes ignore the enable
    // events seen while stretching is off leave no residue for a later enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stretch_cnt <= 7'h00;
        end else if (event_in && (stretch_en || combined)) begin
            stretch_cnt <= stretch_ms;
        end else if (ms_tick && stretch_cnt != 7'h00) begin
            stretch_cnt <= stretch_cnt - 7'h01;
        end
    end
    assign stretched = event_in | (stretch_cnt != 7'h00);

    // blink phase toggles once per ms while a secondary event is stretched
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blink_phase <= 1'b0;
        end else if (!stretched) begin
            blink_phase <= 1'b0;
        end else if (ms_tick) begin
            blink_phase <= ~blink_phase;
        end
    end

    always_comb begin
        next_led = 1'b0;
        unique case (ledic_pkg::ledic_sel_e'(sel))
            ledic_pkg::LEDIC_SEL_SPEED:  next_led = speed_100;
            ledic_pkg::LEDIC_SEL_LINK:   next_led = link_up;
            ledic_pkg::LEDIC_SEL_DUPLEX: next_led = full_duplex;
            ledic_pkg::LEDIC_SEL_TX,
            ledic_pkg::LEDIC_SEL_RX,
            ledic_pkg::LEDIC_SEL_COL,
            ledic_pkg::LEDIC_SEL_ACT:    next_led = stretch_en ? stretched : event_in;
            ledic_pkg::LEDIC_SEL_ON:     next_led = 1'b1;
            ledic_pkg::LEDIC_SEL_OFF:    next_led = 1'b0;
            ledic_pkg::LEDIC_SEL_FAST:   next_led = fast_blink;
            ledic_pkg::LEDIC_SEL_SLOW:   next_led = slow_blink;
            ledic_pkg::LEDIC_SEL_LINK_RX,
            ledic_pkg::LEDIC_SEL_LINK_ACT,
            ledic_pkg::LEDIC_SEL_DUP_COL: next_led = primary ^ (stretched & blink_phase);
            // unused codes keep the lamp dark
            default:                     next_led = 1'b0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            led_on <= 1'b0;
        end else begin
            led_on <= next_led;
        end
    end
endmodule

/* logic/ledic_top.sv */
// indicator control top: AHB-Lite register slave and three indicator channels
// Operation
// - third select field bits 7:4, display codes
// - third select resets to receive display
// - codes 8-B: on, off, fast, slow blink
// - codes 6 and F unused, no display
// - codes C, D, E combined displays
// - link steady on, events toggle lamp
// - full duplex steady on, collisions toggle
// - stretch field bits 3:2, 30/60/100 ms
// - bit 1 global stretch enable, resets 1
// - combined modes always stretch events
// - first select bits 15:12, resets speed
// - second select bits 11:8, resets link
`timescale 1ns/100ps
`include "ledic_defines.svh"
module ledic_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        speed_100,
    input  wire logic        tx_event,
    input  wire logic        rx_event,
    input  wire logic        col_event,
    input  wire logic        link_up,
    input  wire logic        full_duplex,
    output logic [2:0]       led_on
);
    logic [15:0] cfg;
    logic        wr_pend;
    logic        addr_hit;
    logic        ms_tick;
    logic        fast_blink;
    logic        slow_blink;
    logic [6:0]  stretch_ms;
    logic [2:0]  chan_led;
    logic [3:0]  sel [3];

    function automatic logic [6:0] interval_ms(input logic [1:0] code);
        unique case (code)
            2'b00:   interval_ms = 7'(`LEDIC_STRETCH0_MS);
            2'b01:   interval_ms = 7'(`LEDIC_STRETCH1_MS);
            2'b10:   interval_ms = 7'(`LEDIC_STRETCH2_MS);
            // reserved code: fall back to the shortest interval
            default: interval_ms = 7'(`LEDIC_STRETCH0_MS);
        endcase
    endfunction

    wire logic take = hsel & hready & htrans[1];
    assign addr_hit = (haddr == `LEDIC_CFG_OFFSET);

    // zero-wait slave; the write lands at the end of its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
        end else if (hready) begin
            wr_pend <= take & hwrite & addr_hit;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg <= `LEDIC_CFG_RESET;
        end else if (wr_pend) begin
            cfg <= {hwdata[15:1], 1'b0};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (take && !hwrite && addr_hit) begin
            hrdata <= {16'h0000, cfg};
        end else if (take) begin
            hrdata <= 32'h00000000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign stretch_ms = interval_ms(cfg[`LEDIC_FREQ_MSB:`LEDIC_FREQ_LSB]);
    assign sel[0] = cfg[`LEDIC_FIRST_MSB:`LEDIC_FIRST_LSB];
    assign sel[1] = cfg[`LEDIC_SECOND_MSB:`LEDIC_SECOND_LSB];
    assign sel[2] = cfg[`LEDIC_THIRD_MSB:`LEDIC_THIRD_LSB];

    ledic_tick u_tick (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .ms_tick    (ms_tick),
        .fast_blink (fast_blink),
        .slow_blink (slow_blink)
    );

    for (genvar i = 0; i < 3; i++) begin : g_chan
        ledic_channel u_chan (
            .hclk        (hclk),
            .hresetn     (hresetn),
            .sel         (sel[i]),
            .stretch_en  (cfg[`LEDIC_STRETCH_BIT]),
            .stretch_ms  (stretch_ms),
            .ms_tick     (ms_tick),
            .fast_blink  (fast_blink),
            .slow_blink  (slow_blink),
            .speed_100   (speed_100),
            .tx_event    (tx_event),
            .rx_event    (rx_event),
            .col_event   (col_event),
            .link_up     (link_up),
            .full_duplex (full_duplex),
            .led_on      (chan_led[i])
        );
    end

    // channels already register their lamp; one more stage keeps the top outputs flopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            led_on <= 3'b000;
        end else begin
            led_on <= chan_led;
        end
    end
endmodule

/* bench/ledic_monitor.sv */
// port checker of the indicator block, bound to its top
`timescale 1ns/100ps
module ledic_monitor (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        speed_100,
    input wire logic        rx_event,
    input wire logic        link_up,
    input wire logic [2:0]  led_on
);
    logic        wr_pend;
    logic [1:0]  rd_pend;
    logic [15:0] cfg;
    logic [2:0]  stab;
    wire         req = hsel && hready && htrans[1];
    wire  [3:0]  third = cfg[7:4];
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // shadow copy of the configuration; stab counts cycles since the last write, saturating at 7
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 2'b00;
            cfg     <= 16'h0422;
            stab    <= 3'h0;
        end else begin
            wr_pend <= req && hwrite && haddr == 8'h14;
            rd_pend <= {req && !hwrite && haddr == 8'h14, req && !hwrite && haddr != 8'h14};
            cfg     <= wr_pend ? {hwdata[15:1], 1'b0} : cfg;
            stab    <= wr_pend ? 3'h0 : (stab == 3'h7 ? stab : stab + 3'h1);
        end
    end
    chk_bus_okay: assert property (!hresp) else $error("response not okay");
    chk_zero_wait: assert property ($past(hresetn) |-> hreadyout) else $error("slave stalled");
    chk_read_cfg: assert property (rd_pend[1] |-> hrdata == {16'h0, cfg})
        else $error("config read wrong");
    chk_unmapped_zero: assert property (rd_pend[0] |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_first_speed: assert property (cfg[15:12] == 4'h0 && stab > 3
        |-> led_on[0] == $past(speed_100, 2)) else $error("first lamp not speed");
    chk_second_link: assert property (cfg[11:8] == 4'h4 && stab > 3
        |-> led_on[1] == $past(link_up, 2)) else $error("second lamp not link");
    chk_test_on: assert property (third == 4'h8 && stab > 3 |-> led_on[2])
        else $error("test lamp not on");
    chk_unused_dark: assert property (third inside {4'h6, 4'h9, 4'hF} && stab > 3
        |-> !led_on[2]) else $error("dark code lamp on");
    chk_rx_direct: assert property (third == 4'h2 && !cfg[1] && stab > 3
        |-> led_on[2] == $past(rx_event, 2)) else $error("unstretched rx wrong");
    chk_rx_hold: assert property (third == 4'h2 && cfg[1] && stab > 3 && $past(rx_event, 2)
        |-> led_on[2] [*8]) else $error("stretched rx dropped");
endmodule
bind ledic_top ledic_monitor i_ledic_monitor (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .speed_100, .rx_event,
    .link_up, .led_on);

/* bench/ledic_lamp_model.sv */
// lamps hung on the indicator outputs
`timescale 1ns/100ps
module ledic_lamp_model (
    input  wire logic [2:0] led_on,
    output logic      [2:0] lit
);
    // a lamp has no memory: lit exactly while driven
    assign lit = led_on;
endmodule

/* bench/tb_ledic_top.sv */
// self-checking bench of the indicator block
`timescale 1ns/100ps
`define TB_CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    $display("BAD %s exp %h got %h", n, e, g); fail_count++; end end
module tb_ledic_top;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic        hwrite;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [5:0]  st;
    logic [2:0]  led_on;
    logic [2:0]  lit;
    logic [31:0] q;
    int          fail_count;
    int          cmp_count;
    int          cyc;
    // st: speed, tx, rx, collision, link, duplex
    ledic_top i_ledic_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .speed_100(st[5]), .tx_event(st[4]), .rx_event(st[3]), .col_event(st[2]),
        .link_up(st[1]), .full_duplex(st[0]), .led_on);
    ledic_lamp_model i_ledic_lamp_model (.led_on, .lit);
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end
    task automatic results;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        hwrite <= wr;
        haddr  <= a;
        hsize  <= 3'b010;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask
    // lamps settle two edges after an input; four leaves margin
    task automatic hold(input logic [5:0] v);
        st <= v;
        repeat (4) @(posedge hclk);
    endtask
    function automatic logic exp_lamp(input logic [3:0] c, input logic [5:0] v);
        return c < 4'h6 ? v[3'd5 - c[2:0]] : c == 4'h7 ? v[4] | v[3] : c == 4'h8;
    endfunction
    task automatic t_reset;
        hold(6'b100010);
        bus(1'b0, 8'h14, 32'h0);
        `TB_CHK("cfg reset", 32'h0000_0422, q)
        `TB_CHK("reset lamps", 3'b011, lit)
    endtask
    task automatic t_regs;
        bus(1'b1, 8'h14, 32'hFFFF_A5F7);
        bus(1'b0, 8'h14, 32'h0);
        `TB_CHK("cfg write", 32'h0000_A5F6, q)
        bus(1'b1, 8'h18, 32'h0000_1111);
        bus(1'b0, 8'h18, 32'h0);
        `TB_CHK("unmapped read", 32'h0, q)
        bus(1'b0, 8'h14, 32'h0);
        `TB_CHK("cfg kept", 32'h0000_A5F6, q)
    endtask
    // run before any event so no blink phase is pending
    task automatic t_combined;
        for (int c = 12; c < 15; c++) begin
            bus(1'b1, 8'h14, {16'h0, 8'h04, c[3:0], 4'h0});
            hold(6'b000011);
            `TB_CHK("combined steady", 1'b1, lit[2])
            hold(6'b000000);
            `TB_CHK("combined dark", 1'b0, lit[2])
        end
    endtask
    task automatic t_codes;
        logic [5:0] pat [2] = '{6'b101010, 6'b010101};
        for (int c = 0; c < 16; c++) begin
            if (c inside {10, 11, 12, 13, 14}) continue;
            bus(1'b1, 8'h14, {16'h0, {3{c[3:0]}}, 4'h0});
            foreach (pat[p]) begin
                hold(pat[p]);
                `TB_CHK("lamp code", {3{exp_lamp(c[3:0], pat[p])}}, lit)
            end
        end
    endtask
    task automatic t_stretch;
        bus(1'b1, 8'h14, 32'h0000_0426);
        hold(6'b000000);
        `TB_CHK("rx idle dark", 1'b0, lit[2])
        st <= 6'b001000;
        @(posedge hclk);
        hold(6'b000000);
        `TB_CHK("rx stretched", 1'b1, lit[2])
        repeat (2000) @(posedge hclk);
        `TB_CHK("rx still on", 1'b1, lit[2])
        bus(1'b1, 8'h14, 32'h0000_0420);
        hold(6'b000000);
        `TB_CHK("stretch off", 1'b0, lit[2])
    endtask
    initial begin
        hresetn = 1'b0;
        hsel    = 1'b0;
        hwrite  = 1'b0;
        haddr   = 8'h00;
        htrans  = 2'b00;
        hsize   = 3'b000;
        hwdata  = 32'h0;
        st      = 6'b000000;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        t_reset();
        t_regs();
        t_combined();
        t_codes();
        t_stretch();
        results();
    end
endmodule
